// [rtl/rivmap_top.sv]
// Purpose: offers the reset target and interrupt vector addresses to the core
// Assumes: requests come from same-clock logic, fuse from a pin
// Notes: one offer at a time, held until the core acknowledges it
`timescale 1ns/1ps
`include "rivmap_params.svh"
module rivmap_top (
    input wire logic SYS_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic BOOT_RESET_FUSE_IN,
    input wire rivmap_pkg::riv_addr_t BOOT_RESET_ADDR_IN,
    input wire logic VECTOR_BASE_SELECT_IN,
    input wire logic GLOBAL_IRQ_EN_IN,
    input wire rivmap_pkg::riv_req_t IRQ_REQ_IN,
    input wire logic FETCH_ACK_IN,
    output logic FETCH_VALID_OUT,
    output rivmap_pkg::riv_addr_t FETCH_ADDR_OUT,
    output logic FETCH_IS_RESET_OUT,
    output rivmap_pkg::riv_num_t FETCH_NUM_OUT
);
    import rivmap_pkg::*;

    riv_state_s st_q;
    riv_state_s st_d;
    riv_addr_t vec_base;
    riv_addr_t reset_target;

    rivmap_pick_if pick_bus ();

    rivmap_pick u_pick (
        .pick(pick_bus.picker)
    );

    // a masked core sees no new offers, but a pending offer is still held
    assign pick_bus.pending = GLOBAL_IRQ_EN_IN ? IRQ_REQ_IN : '0;

    // boot address is a configuration input, never computed here
    assign reset_target = (st_q.fuse == `RIV_FUSE_PROG) ?
        BOOT_RESET_ADDR_IN : `RIV_RESET_ADDR;
    // base follows the select bit only, independent of the fuse
    assign vec_base = VECTOR_BASE_SELECT_IN ?
        BOOT_RESET_ADDR_IN : `RIV_APP_BASE;

    always_comb begin
        st_d = st_q;
        st_d.fuse_sync = {st_q.fuse_sync[0], BOOT_RESET_FUSE_IN};
        case (st_q.state)
            ST_STRAP: begin
                // wait for the synchroniser to fill before catching the strap
                st_d.strap_cnt = st_q.strap_cnt + 2'h1;
                if (st_q.strap_cnt == 2'(`RIV_SYNC_STAGES)) begin
                    st_d.fuse = st_q.fuse_sync[`RIV_SYNC_STAGES-1];
                    st_d.state = ST_BOOT;
                end
            end
            ST_BOOT: begin
                st_d.is_reset = 1'b1;
                st_d.num = '0;
                st_d.addr = reset_target;
                st_d.state = ST_OFFER;
            end
            ST_IDLE: begin
                if (pick_bus.hit) begin
                    st_d.is_reset = 1'b0;
                    st_d.num = pick_bus.num;
                    st_d.vsel = VECTOR_BASE_SELECT_IN;
                    st_d.pend = pick_bus.pending;
                    st_d.addr = vec_base + riv_vec_ofs(pick_bus.num);
                    st_d.state = ST_OFFER;
                end
            end
            ST_OFFER: begin
                if (FETCH_ACK_IN) begin
                    st_d.is_reset = 1'b0;
                    st_d.state = ST_IDLE;
                end
            end
            default: begin
                st_d.state = ST_STRAP;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            st_q <= '{state: ST_STRAP, fuse_sync: '1, strap_cnt: 2'h0, fuse: 1'b1,
                      vsel: 1'b0, is_reset: 1'b0, num: '0, addr: '0, pend: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign FETCH_VALID_OUT = (st_q.state == ST_OFFER);
    assign FETCH_ADDR_OUT = st_q.addr;
    assign FETCH_IS_RESET_OUT = st_q.is_reset;
    assign FETCH_NUM_OUT = st_q.num;

    // checks on the offers: addresses, order, priority and handshake

    a_reset_app_target: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        FETCH_VALID_OUT && FETCH_IS_RESET_OUT && st_q.fuse
        |-> FETCH_ADDR_OUT == `RIV_RESET_ADDR
    ) else $error("unprogrammed fuse reset target not zero");

    a_reset_boot_target: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        FETCH_VALID_OUT && FETCH_IS_RESET_OUT && !st_q.fuse
        |-> FETCH_ADDR_OUT == $past(BOOT_RESET_ADDR_IN)
    ) else $error("programmed fuse reset target not boot address");

    a_reset_first_offer: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        $rose(st_q.state == ST_BOOT) |=> FETCH_VALID_OUT && FETCH_IS_RESET_OUT
    ) else $error("reset target not offered first");

    a_ext_zero_slot: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        $rose(FETCH_VALID_OUT) && !FETCH_IS_RESET_OUT && !st_q.vsel
            && FETCH_NUM_OUT == 5'h00
        |-> FETCH_ADDR_OUT == `RIV_OFS_EXT0
    ) else $error("external request zero vector misplaced");

    a_table_offset: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        FETCH_VALID_OUT && !FETCH_IS_RESET_OUT && !st_q.vsel
        |-> FETCH_ADDR_OUT == riv_addr_t'(FETCH_NUM_OUT) + 16'h0001
    ) else $error("vector not at its table offset");

    a_last_entry: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        FETCH_VALID_OUT && !FETCH_IS_RESET_OUT && !st_q.vsel && FETCH_NUM_OUT == 5'h19
        |-> FETCH_ADDR_OUT == 16'h001a
    ) else $error("serial start edge vector misplaced");

    a_relocated_vec: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        $rose(FETCH_VALID_OUT) && !FETCH_IS_RESET_OUT && st_q.vsel
        |-> FETCH_ADDR_OUT == $past(BOOT_RESET_ADDR_IN) + riv_vec_ofs(FETCH_NUM_OUT)
    ) else $error("relocated vector not boot base plus offset");

    a_base_indep: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        $rose(FETCH_VALID_OUT) && !FETCH_IS_RESET_OUT && st_q.fuse && st_q.vsel
            && FETCH_NUM_OUT == 5'h00
        |-> FETCH_ADDR_OUT == $past(BOOT_RESET_ADDR_IN) + 16'h0001
    ) else $error("vector base tied to fuse");

    a_lowest_first: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        FETCH_VALID_OUT && !FETCH_IS_RESET_OUT
        |-> st_q.pend[FETCH_NUM_OUT]
            && (st_q.pend & ((riv_req_t'(1) << FETCH_NUM_OUT) - riv_req_t'(1))) == '0
    ) else $error("lower pending request skipped");

    a_offer_held: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        FETCH_VALID_OUT && !FETCH_ACK_IN
        |=> FETCH_VALID_OUT && $stable(FETCH_ADDR_OUT) && $stable(FETCH_NUM_OUT)
    ) else $error("offer changed before acknowledge");

    a_ack_release: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        FETCH_VALID_OUT && FETCH_ACK_IN |=> !FETCH_VALID_OUT
    ) else $error("offer not released after acknowledge");
endmodule : rivmap_top

// [rtl/rivmap_params.svh]
// Purpose: constants of the reset and interrupt vector map
// Assumes: word addresses on the program memory side
// Notes: offsets are relative to the vector base
`ifndef RIVMAP_PARAMS_SVH
`define RIVMAP_PARAMS_SVH
`define RIV_ADDR_W 16
`define RIV_NUM_IRQ 26
`define RIV_NUM_W 5
`define RIV_SYNC_STAGES 2
`define RIV_RESET_ADDR 16'h0000
`define RIV_APP_BASE 16'h0000
`define RIV_FUSE_PROG 1'b0
`define RIV_OFS_EXT0 16'h0001
`define RIV_OFS_EXT1 16'h0002
`define RIV_OFS_PCG0 16'h0003
`define RIV_OFS_PCG1 16'h0004
`define RIV_OFS_PCG2 16'h0005
`define RIV_OFS_WDOG 16'h0006
`define RIV_OFS_T2MA 16'h0007
`define RIV_OFS_T2MB 16'h0008
`define RIV_OFS_T2WR 16'h0009
`define RIV_OFS_T1CP 16'h000a
`define RIV_OFS_T1MA 16'h000b
`define RIV_OFS_T1MB 16'h000c
`define RIV_OFS_T1WR 16'h000d
`define RIV_OFS_T0MA 16'h000e
`define RIV_OFS_T0MB 16'h000f
`define RIV_OFS_T0WR 16'h0010
`define RIV_OFS_SPI 16'h0011
`define RIV_OFS_SRX 16'h0012
`define RIV_OFS_STXE 16'h0013
`define RIV_OFS_STX 16'h0014
`define RIV_OFS_ADC 16'h0015
`define RIV_OFS_EEP 16'h0016
`define RIV_OFS_CMP 16'h0017
`define RIV_OFS_TWO 16'h0018
`define RIV_OFS_STORE 16'h0019
`define RIV_OFS_SSTART 16'h001a
`endif

// [rtl/rivmap_pkg.sv]
// Purpose: types and offset lookup of the vector map
// Assumes: rivmap_params.svh on the include path
// Notes: request index 0 is external request zero, 25 is serial start edge
`include "rivmap_params.svh"
package rivmap_pkg;
    typedef logic [`RIV_ADDR_W-1:0] riv_addr_t;
    typedef logic [`RIV_NUM_IRQ-1:0] riv_req_t;
    typedef logic [`RIV_NUM_W-1:0] riv_num_t;

    typedef enum logic [1:0] {
        ST_STRAP = 2'h0,
        ST_BOOT = 2'h1,
        ST_IDLE = 2'h2,
        ST_OFFER = 2'h3
    } riv_state_e;

    typedef struct packed {
        riv_state_e state;
        logic [`RIV_SYNC_STAGES-1:0] fuse_sync;
        logic [1:0] strap_cnt;
        logic fuse;
        logic vsel;
        logic is_reset;
        riv_num_t num;
        riv_addr_t addr;
        riv_req_t pend;
    } riv_state_s;

    function automatic riv_addr_t riv_vec_ofs(input riv_num_t n);
        case (n)
            5'h00: riv_vec_ofs = `RIV_OFS_EXT0;
            5'h01: riv_vec_ofs = `RIV_OFS_EXT1;
            5'h02: riv_vec_ofs = `RIV_OFS_PCG0;
            5'h03: riv_vec_ofs = `RIV_OFS_PCG1;
            5'h04: riv_vec_ofs = `RIV_OFS_PCG2;
            5'h05: riv_vec_ofs = `RIV_OFS_WDOG;
            5'h06: riv_vec_ofs = `RIV_OFS_T2MA;
            5'h07: riv_vec_ofs = `RIV_OFS_T2MB;
            5'h08: riv_vec_ofs = `RIV_OFS_T2WR;
            5'h09: riv_vec_ofs = `RIV_OFS_T1CP;
            5'h0a: riv_vec_ofs = `RIV_OFS_T1MA;
            5'h0b: riv_vec_ofs = `RIV_OFS_T1MB;
            5'h0c: riv_vec_ofs = `RIV_OFS_T1WR;
            5'h0d: riv_vec_ofs = `RIV_OFS_T0MA;
            5'h0e: riv_vec_ofs = `RIV_OFS_T0MB;
            5'h0f: riv_vec_ofs = `RIV_OFS_T0WR;
            5'h10: riv_vec_ofs = `RIV_OFS_SPI;
            5'h11: riv_vec_ofs = `RIV_OFS_SRX;
            5'h12: riv_vec_ofs = `RIV_OFS_STXE;
            5'h13: riv_vec_ofs = `RIV_OFS_STX;
            5'h14: riv_vec_ofs = `RIV_OFS_ADC;
            5'h15: riv_vec_ofs = `RIV_OFS_EEP;
            5'h16: riv_vec_ofs = `RIV_OFS_CMP;
            5'h17: riv_vec_ofs = `RIV_OFS_TWO;
            5'h18: riv_vec_ofs = `RIV_OFS_STORE;
            5'h19: riv_vec_ofs = `RIV_OFS_SSTART;
            default: riv_vec_ofs = `RIV_RESET_ADDR;
        endcase
    endfunction : riv_vec_ofs
endpackage : rivmap_pkg

// [rtl/rivmap_pick_if.sv]
// Purpose: carries pending requests to the picker and the winner back
// Assumes: one clock domain, purely combinational path
// Notes: hit is low when nothing is pending
`timescale 1ns/1ps
interface rivmap_pick_if;
    import rivmap_pkg::*;
    riv_req_t pending;
    logic hit;
    riv_num_t num;
    modport picker (input pending, output hit, output num);
    modport user (output pending, input hit, input num);
endinterface : rivmap_pick_if

// [rtl/rivmap_pick.sv]
// Purpose: fixed priority pick of the lowest pending request
// Assumes: requests already gated by their local enables
// Notes: lowest index equals lowest table address
`timescale 1ns/1ps
`include "rivmap_params.svh"
module rivmap_pick (
    rivmap_pick_if.picker pick
);
    import rivmap_pkg::*;

    logic [`RIV_NUM_IRQ:0] below;
    riv_req_t grant;

    assign below[0] = 1'b0;
    genvar gi;
    generate
        for (gi = 0; gi < `RIV_NUM_IRQ; gi++) begin : g_chain
            assign below[gi+1] = below[gi] | pick.pending[gi];
            assign grant[gi] = pick.pending[gi] & ~below[gi];
        end
    endgenerate

    always_comb begin
        pick.num = '0;
        for (int i = 0; i < `RIV_NUM_IRQ; i++) begin
            if (grant[i]) begin
                pick.num = pick.num | riv_num_t'(i);
            end
        end
    end

    assign pick.hit = below[`RIV_NUM_IRQ];
endmodule : rivmap_pick

// [testbench/rivmap_core_model.sv]
// Purpose: core side that takes fetch offers and keeps what it took
// Assumes: offer stands until the core acks it
// Notes: delay_in picks a prompt (0) or slow core
`timescale 1ns/1ps
module rivmap_core_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic valid_in,
    input wire rivmap_pkg::riv_addr_t addr_in,
    input wire logic is_reset_in,
    input wire rivmap_pkg::riv_num_t num_in,
    input wire logic [3:0] delay_in,
    output logic ack_out,
    output logic took_out,
    output rivmap_pkg::riv_addr_t addr_out,
    output logic is_reset_out,
    output rivmap_pkg::riv_num_t num_out
);
    import rivmap_pkg::*;
    logic [3:0] wait_q;
    // ack launched after an edge, dropped right after the edge that used it
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_out <= 1'b0;
            took_out <= 1'b0;
            wait_q <= 4'h0;
            addr_out <= '0;
            is_reset_out <= 1'b0;
            num_out <= '0;
        end else begin
            took_out <= 1'b0;
            if (valid_in && ack_out) begin
                ack_out <= 1'b0;
                took_out <= 1'b1;
                wait_q <= 4'h0;
                addr_out <= addr_in;
                is_reset_out <= is_reset_in;
                num_out <= num_in;
            end else if (valid_in) begin
                if (wait_q >= delay_in) ack_out <= 1'b1;
                else wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule : rivmap_core_model

// [testbench/reset_interrupt_vector_map_tb.sv]
// Purpose: self-checking bench of the vector map
// Assumes: core model acks every offer, bench clears the source it served
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module reset_interrupt_vector_map_tb;
    import rivmap_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, fuse = 1'b1, vsel = 1'b0, gie = 1'b0;
    logic ack, valid, is_rst, took, t_rst;
    riv_addr_t boot = 16'h0c00, addr, t_addr;
    riv_req_t req = '0;
    riv_num_t num, t_num;
    logic [3:0] dly = 4'h0;
    int n_mismatch = 0, cmp_count = 0, cyc = 0;

    rivmap_top rivmap_top_i (.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .BOOT_RESET_FUSE_IN(fuse),
        .BOOT_RESET_ADDR_IN(boot), .VECTOR_BASE_SELECT_IN(vsel), .GLOBAL_IRQ_EN_IN(gie),
        .IRQ_REQ_IN(req), .FETCH_ACK_IN(ack), .FETCH_VALID_OUT(valid),
        .FETCH_ADDR_OUT(addr), .FETCH_IS_RESET_OUT(is_rst), .FETCH_NUM_OUT(num));
    rivmap_core_model rivmap_core_model_i (.clk_in(clk), .rst_n_in(rst_n), .valid_in(valid),
        .addr_in(addr), .is_reset_in(is_rst), .num_in(num), .delay_in(dly), .ack_out(ack),
        .took_out(took), .addr_out(t_addr), .is_reset_out(t_rst), .num_out(t_num));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask : chk

    // waits for one taken offer; bounded so a missing offer cannot hang
    task automatic take_one;
        int i;
        for (i = 0; i < 60; i++) begin
            @(posedge clk);
            #1;
            if (took === 1'b1) break;
        end
        chk("offer_taken", 16'h0001, {15'h0, took});
    endtask : take_one

    task automatic t_reset(input logic f, input riv_addr_t exp);
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        fuse = f;
        req = '0;
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        take_one();
        chk("reset_addr", exp, t_addr);
        chk("reset_flag", 16'h0001, {15'h0, t_rst});
    endtask : t_reset

    // one source at a time, every table entry
    task automatic t_each(input logic sel);
        int i;
        riv_addr_t base;
        base = sel ? boot : 16'h0000;
        vsel = sel;
        gie = 1'b1;
        for (i = 0; i < 26; i++) begin
            req = riv_req_t'(1) << i;
            take_one();
            req = '0;
            // let an edge pass so the next request is a separate write
            @(posedge clk);
            #1;
            chk("vec_num", 16'(i), {11'h0, t_num});
            chk("vec_addr", base + 16'(i) + 16'h0001, t_addr);
            chk("vec_flag", 16'h0000, {15'h0, t_rst});
        end
    endtask : t_each

    // several pending at once, served lowest first, slow core
    task automatic t_prio;
        int k;
        int ord[4] = '{0, 3, 7, 25};
        riv_req_t set_req;
        set_req = '0;
        vsel = 1'b0;
        dly = 4'h3;
        gie = 1'b0;
        // one write of the request word, not one per bit
        for (k = 0; k < 4; k++) set_req[ord[k]] = 1'b1;
        req = set_req;
        repeat (10) @(posedge clk);
        #1;
        chk("gated_valid", 16'h0000, {15'h0, valid});
        gie = 1'b1;
        for (k = 0; k < 4; k++) begin
            take_one();
            req[t_num] = 1'b0;
            chk("prio_num", 16'(ord[k]), {11'h0, t_num});
            chk("prio_addr", 16'(ord[k]) + 16'h0001, t_addr);
        end
        dly = 4'h0;
        @(posedge clk);
        #1;
    endtask : t_prio

    // select chosen here, fuse left as the last t_reset strapped it
    task automatic t_mix(input logic sel, input riv_addr_t exp);
        vsel = sel;
        gie = 1'b1;
        req = riv_req_t'(1);
        take_one();
        req = '0;
        @(posedge clk);
        #1;
        chk("mix_addr", exp, t_addr);
    endtask : t_mix

    initial begin
        t_reset(1'b1, 16'h0000);
        t_each(1'b0);
        t_each(1'b1);
        t_prio();
        t_mix(1'b1, boot + 16'h0001);
        boot = 16'h1e00;
        t_reset(1'b0, 16'h1e00);
        t_mix(1'b0, 16'h0001);
        t_mix(1'b1, 16'h1e01);
        boot = 16'h0c00;
        t_reset(1'b0, 16'h0c00);
        finish_test();
    end
endmodule : reset_interrupt_vector_map_tb
